//--- shrp_dev.sv
module shrp_dev (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   shrp_link_if.dev lnk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output logic fifo_hit,
   output logic [shrp_pkg::FIFO_PTR_W-1:0] fifo_ptr,
   output logic monitor_slave_mode,
   output logic hdr_reject,
   input wire logic irq_req,
   input wire logic irq_active_high
);
   import shrp_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_HDR, S_ADDR, S_SLOT, S_WDATA, S_BURST, S_CONST, S_IGNORE
   } shrp_state_e;

   // ----------------------------------------------------------
   // pin synchronisers and agreement filter
   // ----------------------------------------------------------
   logic [2:0] raw;
   logic [2:0] s1_q, s2_q, s3_q, filt_q;
   wire [2:0] agree = ~(s2_q ^ s3_q);
   wire [2:0] filt_d = (s3_q & agree) | (filt_q & ~agree);
   logic strap_q;

   assign raw = {lnk.sclk, lnk.cs_n, lnk.serial_data_in};

   // three stages, no reset on the data path
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // filtered levels change once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         filt_q <= DEV_FILT_RST;
      end else if (ce) begin
         filt_q <= filt_d;
      end
   end

   // select level caught while reset is held
   always_ff @(posedge ref_clk) begin
      if (rst && ce) begin
         strap_q <= s3_q[1];
      end
   end

   assign monitor_slave_mode = ~strap_q;

   // ----------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------
   wire sclk_rise = filt_d[2] & ~filt_q[2];
   wire sclk_fall = ~filt_d[2] & filt_q[2];
   wire cs_fall = ~filt_d[1] & filt_q[1] & strap_q;
   wire sel = ~filt_q[1] & strap_q;
   wire sdi_f = filt_q[0];

   logic [2:0] bit_q;
   logic [6:0] sh_q;
   wire byte_done = sclk_rise & sel & (bit_q == LAST_BIT);
   wire [7:0] byte_in = {sh_q, sdi_f};

   // msb-first receive shifter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bit_q <= 3'h0;
         sh_q <= 7'h00;
      end else if (ce) begin
         if (!sel) begin
            bit_q <= 3'h0;
         end else if (sclk_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q <= byte_in[6:0];
         end
      end
   end

   // ----------------------------------------------------------
   // header decode and address forms
   // ----------------------------------------------------------
   wire [7:0] hdr_base = byte_in & ~HDR_HALF_MASK;
   wire hdr_ok = (hdr_base == HDR_ALT_NI) || (hdr_base == HDR_ALT_IL) ||
      (hdr_base == HDR_CONST) || (hdr_base == HDR_RW_NI) || (hdr_base == HDR_RW_IL);
   shrp_mode_e hdr_mode;

   // sequence type from header code
   always_comb begin
      if (hdr_base == HDR_ALT_IL) begin
         hdr_mode = SHRP_ALT_IL;
      end else if (hdr_base == HDR_CONST) begin
         hdr_mode = SHRP_CONST;
      end else if (hdr_base == HDR_RW_NI) begin
         hdr_mode = SHRP_RW_NI;
      end else if (hdr_base == HDR_RW_IL) begin
         hdr_mode = SHRP_RW_IL;
      end else begin
         hdr_mode = SHRP_ALT_NI;
      end
   end

   function automatic logic is_fifo(input logic [7:0] a);
      is_fifo = (a <= FIFO_LAST_ADR) || (a == FIFO_ALIAS0) || (a == FIFO_ALIAS1);
   endfunction

   // ----------------------------------------------------------
   // sequence state machine
   // ----------------------------------------------------------
   shrp_state_e state_q, state_d;
   shrp_mode_e mode_q, mode_d;
   logic half_q, half_d, crd_q, crd_d, rd_d, wr_d, hit_d, rej_d;
   logic [7:0] addr_q, addr_d, wdat_d;
   logic [FIFO_PTR_W-1:0] ptr_d;
   wire byte_rd = byte_in[ADR_RD_BIT];
   wire [7:0] byte_adr = {half_q, byte_in[6:0]};
   wire mode_ni = (mode_q == SHRP_ALT_NI) || (mode_q == SHRP_RW_NI);
   wire mode_rw = (mode_q == SHRP_RW_NI) || (mode_q == SHRP_RW_IL);

   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      half_d = half_q;
      crd_d = crd_q;
      addr_d = addr_q;
      wdat_d = reg_wdata;
      ptr_d = fifo_ptr;
      hit_d = fifo_hit;
      rej_d = hdr_reject;
      rd_d = 1'b0;
      wr_d = 1'b0;
      if (cs_fall) begin
         state_d = S_HDR;
         rej_d = 1'b0;
      end else if (!sel) begin
         state_d = S_IDLE;
      end else if (byte_done) begin
         case (state_q)
            S_HDR: begin
               mode_d = hdr_mode;
               half_d = byte_in[HDR_HALF_BIT];
               state_d = hdr_ok ? S_ADDR : S_IGNORE;
               rej_d = ~hdr_ok;
            end
            S_ADDR: begin
               addr_d = byte_adr;
               if (mode_q == SHRP_CONST) begin
                  state_d = S_CONST;
                  crd_d = byte_rd;
                  rd_d = byte_rd;
                  ptr_d = FIFO_PTR_RST;
                  hit_d = is_fifo(byte_adr);
               end else if (byte_rd) begin
                  rd_d = 1'b1;
                  state_d = mode_ni ? S_SLOT : S_ADDR;
               end else begin
                  state_d = mode_rw ? S_BURST : S_WDATA;
               end
            end
            S_SLOT: state_d = S_ADDR;
            S_WDATA: begin
               wr_d = 1'b1;
               wdat_d = byte_in;
               state_d = S_ADDR;
            end
            S_BURST: begin
               wr_d = 1'b1;
               wdat_d = byte_in;
            end
            S_CONST: begin
               ptr_d = hit_d ? fifo_ptr + 1'b1 : fifo_ptr;
               rd_d = crd_q;
               wr_d = ~crd_q;
               wdat_d = byte_in;
            end
            default: state_d = state_q;
         endcase
      end
   end

   // sequence registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= S_IDLE;
         mode_q <= SHRP_ALT_NI;
         half_q <= 1'b0;
         crd_q <= 1'b0;
         addr_q <= 8'h00;
         reg_wdata <= 8'h00;
         reg_rd <= 1'b0;
         reg_wr <= 1'b0;
         fifo_ptr <= FIFO_PTR_RST;
         fifo_hit <= 1'b0;
         hdr_reject <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         mode_q <= mode_d;
         half_q <= half_d;
         crd_q <= crd_d;
         addr_q <= addr_d;
         reg_wdata <= wdat_d;
         reg_rd <= rd_d;
         reg_wr <= wr_d;
         fifo_ptr <= ptr_d;
         fifo_hit <= hit_d;
         hdr_reject <= rej_d;
      end
   end

   assign reg_addr = addr_q;

   // ----------------------------------------------------------
   // read data output shifter
   // ----------------------------------------------------------
   logic [7:0] rbuf_q, osh_q;
   logic ld_q, oact_q;
   logic [2:0] ocnt_q;

   // load on the falling edge closing the address byte
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rbuf_q <= 8'h00;
         osh_q <= 8'h00;
         ld_q <= 1'b0;
         oact_q <= 1'b0;
         ocnt_q <= 3'h0;
      end else if (ce) begin
         if (!sel) begin
            ld_q <= 1'b0;
            oact_q <= 1'b0;
         end else if (reg_rd) begin
            rbuf_q <= reg_rdata;
            ld_q <= 1'b1;
         end else if (sclk_fall && ld_q) begin
            osh_q <= rbuf_q;
            ld_q <= 1'b0;
            oact_q <= 1'b1;
            ocnt_q <= 3'h0;
         end else if (sclk_fall && oact_q) begin
            oact_q <= (ocnt_q != LAST_BIT);
            osh_q <= {osh_q[6:0], 1'b0};
            ocnt_q <= ocnt_q + 3'h1;
         end
      end
   end

   assign lnk.serial_data_out = osh_q[7];
   assign lnk.serial_data_out_oe = oact_q & sel;

   // ----------------------------------------------------------
   // interrupt request pin
   // ----------------------------------------------------------
   logic irq_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_q <= IRQ_RST;
      end else if (ce) begin
         irq_q <= irq_active_high ? irq_req : ~irq_req;
      end
   end

   assign lnk.irq_pin = irq_q;
endmodule

//--- shrp_pkg.sv
package shrp_pkg;
   // ----------------------------------------------------------
   // header codes (lower half) and field positions
   // ----------------------------------------------------------
   localparam logic [7:0] HDR_ALT_NI = 8'h40;
   localparam logic [7:0] HDR_ALT_IL = 8'h48;
   localparam logic [7:0] HDR_CONST = 8'h43;
   localparam logic [7:0] HDR_RW_NI = 8'h41;
   localparam logic [7:0] HDR_RW_IL = 8'h49;
   localparam logic [7:0] HDR_HALF_MASK = 8'h04;
   localparam int HDR_HALF_BIT = 2;
   localparam int ADR_RD_BIT = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // ----------------------------------------------------------
   // fifo window
   // ----------------------------------------------------------
   localparam logic [7:0] FIFO_LAST_ADR = 8'h1f;
   localparam logic [7:0] FIFO_ALIAS0 = 8'h6a;
   localparam logic [7:0] FIFO_ALIAS1 = 8'h7a;
   localparam int FIFO_PTR_W = 8;
   localparam logic [FIFO_PTR_W-1:0] FIFO_PTR_RST = 8'h00;
   // ----------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------
   localparam logic IRQ_RST = 1'b1;
   localparam logic CS_N_RST = 1'b1;
   localparam logic [2:0] DEV_FILT_RST = 3'h2;
   localparam logic [1:0] HOST_FILT_RST = 2'h0;
   localparam int REF_CLK_HZ = 40_000_000;
   localparam int SCLK_HZ = 2_500_000;
   localparam int HALF_CYC = REF_CLK_HZ / (2 * SCLK_HZ);
   localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);

   typedef enum logic [2:0] {
      SHRP_ALT_NI, SHRP_ALT_IL, SHRP_CONST, SHRP_RW_NI, SHRP_RW_IL
   } shrp_mode_e;
endpackage

//--- shrp_link_if.sv
// serial link between host and device
interface shrp_link_if;
   logic sclk;
   logic cs_n;
   logic serial_data_in;
   logic serial_data_in_oe;
   logic serial_data_out;
   logic serial_data_out_oe;
   logic irq_pin;

   modport dev (
      input sclk, cs_n, serial_data_in,
      output serial_data_out, serial_data_out_oe, irq_pin
   );
   modport host (
      output sclk, cs_n, serial_data_in, serial_data_in_oe,
      input serial_data_out, irq_pin
   );
endinterface

//--- shrp_host.sv
module shrp_host (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   shrp_link_if.host lnk,
   input wire logic frame_req,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_release,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic irq_pin_level
);
   import shrp_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} shrp_hstate_e;

   // ----------------------------------------------------------
   // synchronisers for device outputs
   // ----------------------------------------------------------
   logic [1:0] s1_q, s2_q, s3_q, filt_q;
   wire [1:0] agree = ~(s2_q ^ s3_q);

   always_ff @(posedge ref_clk) begin
      if (ce) begin
         s1_q <= {lnk.irq_pin, lnk.serial_data_out};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         filt_q <= HOST_FILT_RST;
      end else if (ce) begin
         filt_q <= (s3_q & agree) | (filt_q & ~agree);
      end
   end

   assign irq_pin_level = filt_q[1];

   // ----------------------------------------------------------
   // byte engine with divided serial clock
   // ----------------------------------------------------------
   shrp_hstate_e st_q, st_d;
   logic cs_n_q, cs_n_d, sclk_q, sclk_d, rel_q, rel_d, rxv_d;
   logic [3:0] div_q, div_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d, rx_d;
   wire half_done = (div_q == HALF_CNT);

   assign tx_ready = ce & (st_q == H_IDLE) & ~cs_n_q & frame_req;

   always_comb begin
      st_d = st_q;
      cs_n_d = cs_n_q;
      sclk_d = sclk_q;
      rel_d = rel_q;
      div_d = div_q + 4'h1;
      bit_d = bit_q;
      tsh_d = tsh_q;
      rsh_d = rsh_q;
      rx_d = rx_data;
      rxv_d = 1'b0;
      case (st_q)
         H_IDLE: begin
            div_d = 4'h0;
            if (tx_valid && tx_ready) begin
               tsh_d = tx_data;
               rel_d = tx_release;
               bit_d = 3'h0;
               st_d = H_LOW;
            end else if (frame_req && cs_n_q) begin
               cs_n_d = 1'b0;
            end else if (!frame_req && !cs_n_q) begin
               cs_n_d = 1'b1;
               st_d = H_GAP;
            end
         end
         H_LOW: if (half_done) begin
            sclk_d = 1'b1;
            div_d = 4'h0;
            st_d = H_HIGH;
         end
         H_HIGH: if (half_done) begin
            sclk_d = 1'b0;
            div_d = 4'h0;
            rsh_d = {rsh_q[6:0], filt_q[0]};
            tsh_d = {tsh_q[6:0], 1'b0};
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT) begin
               rx_d = {rsh_q[6:0], filt_q[0]};
               rxv_d = 1'b1;
               st_d = H_IDLE;
            end else begin
               st_d = H_LOW;
            end
         end
         default: if (half_done) begin
            st_d = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= H_IDLE;
         cs_n_q <= CS_N_RST;
         sclk_q <= 1'b0;
         rel_q <= 1'b0;
         div_q <= 4'h0;
         bit_q <= 3'h0;
         tsh_q <= 8'h00;
         rsh_q <= 8'h00;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         cs_n_q <= cs_n_d;
         sclk_q <= sclk_d;
         rel_q <= rel_d;
         div_q <= div_d;
         bit_q <= bit_d;
         tsh_q <= tsh_d;
         rsh_q <= rsh_d;
         rx_data <= rx_d;
         rx_valid <= rxv_d;
      end
   end

   assign lnk.sclk = sclk_q;
   assign lnk.cs_n = cs_n_q;
   assign lnk.serial_data_in = tsh_q[7];
   assign lnk.serial_data_in_oe = ~rel_q & ((st_q == H_LOW) | (st_q == H_HIGH));
endmodule

//--- shrp_link_checker.sv
module shrp_link_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_in,
   input wire logic serial_data_in_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic irq_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // -----------------------------
   // helper: length of a drive slot
   // -----------------------------
   logic [9:0] oe_cnt_q;
   logic sclk_q;
   wire sclk_fall = sclk_q & ~sclk;
   // counts clock falls while the device drives; gaps between bytes do not matter
   always_ff @(posedge ref_clk) begin
      sclk_q <= sclk;
      if (rst || !serial_data_out_oe) oe_cnt_q <= 10'h000;
      else if (sclk_fall) oe_cnt_q <= oe_cnt_q + 10'h001;
   end
   // -----------------------------
   // assertions
   // -----------------------------
   idle_out_off_a: assert property (
      cs_n [*8] |-> !serial_data_out_oe) else $error("data out driven while deselected");
   sclk_idle_a: assert property (
      cs_n |-> !sclk) else $error("serial clock active while deselected");
   sclk_high_a: assert property (
      $rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("serial clock high phase wrong");
   sclk_low_a: assert property (
      $fell(sclk) |-> !sclk [*8]) else $error("serial clock low phase short");
   din_stable_a: assert property (
      $rose(sclk) && serial_data_in_oe |-> $stable(serial_data_in))
      else $error("data in moved at clock rise");
   dout_on_fall_a: assert property (
      serial_data_out_oe && $changed(serial_data_out) |-> !sclk)
      else $error("data out moved while clock high");
   slot_length_a: assert property (
      $fell(serial_data_out_oe) |-> oe_cnt_q[2:0] == 3'h0 && oe_cnt_q != 10'h000)
      else $error("drive slot not whole bytes");
   cs_fall_clean_a: assert property (
      $fell(cs_n) |-> !sclk [*8]) else $error("clock edge too soon after select");
   cs_high_min_a: assert property (
      $rose(cs_n) |-> cs_n [*8]) else $error("select high too short");
   // main scenarios
   frame_c: cover property ($fell(cs_n));
   slot_c: cover property ($rose(serial_data_out_oe));
   irq_c: cover property ($fell(irq_pin));
endmodule

//--- shrp_bench.sv
module shrp_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import shrp_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, frame_req = 1'b0, tx_valid = 1'b0, tx_release = 1'b0;
   logic irq_req = 1'b0, irq_active_high = 1'b0, ce = 1'b1;
   logic [7:0] tx_data = 8'h00;
   logic tx_ready, rx_valid, irq_pin_level, reg_wr, reg_rd, fifo_hit, mon_mode, hdr_reject;
   logic [7:0] rx_data, reg_addr, reg_wdata, reg_rdata, fifo_ptr, last_wa, last_wd;
   logic [7:0] rxq[$];
   int miscompares = 0, n_checks = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0, b0, b1;
   // -----------------------------
   // both ends and checker
   // -----------------------------
   shrp_link_if lnk();
   shrp_dev u_shrp_dev (.ref_clk(ref_clk), .rst(rst), .ce(ce), .lnk(lnk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fifo_hit(fifo_hit), .fifo_ptr(fifo_ptr),
      .monitor_slave_mode(mon_mode), .hdr_reject(hdr_reject), .irq_req(irq_req),
      .irq_active_high(irq_active_high));
   shrp_host u_shrp_host (.ref_clk(ref_clk), .rst(rst), .ce(ce), .lnk(lnk),
      .frame_req(frame_req), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_release(tx_release), .rx_valid(rx_valid), .rx_data(rx_data),
      .irq_pin_level(irq_pin_level));
   shrp_link_checker u_shrp_link_checker (.ref_clk(ref_clk), .rst(rst), .sclk(lnk.sclk),
      .cs_n(lnk.cs_n), .serial_data_in(lnk.serial_data_in),
      .serial_data_in_oe(lnk.serial_data_in_oe), .serial_data_out(lnk.serial_data_out),
      .serial_data_out_oe(lnk.serial_data_out_oe), .irq_pin(lnk.irq_pin));
   // register file stand-in: read data is the inverted address
   assign reg_rdata = ~reg_addr;
   // clock
   always #12.5 ref_clk = ~ref_clk;
   // register access monitor and hang limit
   always @(posedge ref_clk) begin
      cyc++;
      if (reg_wr === 1'b1) begin
         wr_cnt++;
         last_wa = reg_addr;
         last_wd = reg_wdata;
      end
      if (reg_rd === 1'b1) rd_cnt++;
      if (cyc == 40000) begin
         miscompares++;
         close_out();
      end
   end
   // -----------------------------
   // shared tasks
   // -----------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] b, input logic rel);
      int n;
      n = 0;
      @(negedge ref_clk);
      tx_valid = 1'b1;
      tx_data = b;
      tx_release = rel;
      while (tx_ready !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      tx_valid = 1'b0;
      while (rx_valid !== 1'b1 && n < 600) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 600) miscompares++;
      rxq.push_back(rx_data);
   endtask
   task automatic frame(input logic [7:0] bq[$], input logic [7:0] rel);
      rxq = {};
      b0 = wr_cnt;
      b1 = rd_cnt;
      @(negedge ref_clk);
      frame_req = 1'b1;
      foreach (bq[i]) xfer(bq[i], rel[i]);
      @(negedge ref_clk);
      frame_req = 1'b0;
      repeat (30) @(negedge ref_clk);
   endtask
   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_alt();
      for (int h = 0; h < 2; h++) begin
         frame({8'h40 | 8'(h << 2), 8'h12, 8'ha5}, 8'h00);
         check(16'(wr_cnt - b0), 16'h1);
         check(last_wa, {1'(h), 7'h12});
         check(last_wd, 8'ha5);
      end
      frame({8'h44, 8'h85, 8'h00}, 8'h04);
      check(16'(rd_cnt - b1), 16'h1);
      check(rxq[2], 8'h7a);
      frame({8'h48, 8'h81, 8'h82, 8'h10, 8'h11}, 8'h00);
      check(rxq[2], 8'hfe);
      check(rxq[3], 8'hfd);
      check(last_wa, 8'h10);
      check(last_wd, 8'h11);
      $display("test alternating done");
   endtask
   task automatic t_rw();
      frame({8'h41, 8'h81, 8'h00, 8'h10, 8'h21, 8'h22}, 8'h04);
      check(rxq[2], 8'hfe);
      check(16'(wr_cnt - b0), 16'h2);
      check(last_wd, 8'h22);
      frame({8'h4d, 8'h81, 8'h82, 8'h10, 8'h21, 8'h22}, 8'h00);
      check(rxq[2], 8'h7e);
      check(rxq[3], 8'h7d);
      check(16'(wr_cnt - b0), 16'h2);
      check(last_wa, 8'h90);
      $display("test read then write done");
   endtask
   task automatic t_const();
      frame({8'h43, 8'h05, 8'h01, 8'h02, 8'h03}, 8'h00);
      check(16'(wr_cnt - b0), 16'h3);
      check(last_wa, 8'h05);
      check(last_wd, 8'h03);
      check(fifo_hit, 1'b1);
      check(fifo_ptr, 8'h03);
      frame({8'h43, 8'h40, 8'h01, 8'h02}, 8'h00);
      check(fifo_hit, 1'b0);
      check(fifo_ptr, 8'h00);
      // constant-address read in the upper half, both data slots released
      frame({8'h47, 8'h81, 8'h00, 8'h00}, 8'h0c);
      check(rxq[2], 8'h7e);
      check(rxq[3], 8'h7e);
      check(16'(wr_cnt - b0), 16'h0);
      check(fifo_hit, 1'b0);
      $display("test constant address done");
   endtask
   task automatic t_reject();
      frame({8'h55, 8'h12, 8'h34}, 8'h00);
      check(16'(wr_cnt - b0), 16'h0);
      check(hdr_reject, 1'b1);
      frame({8'h40, 8'h12, 8'h66}, 8'h00);
      check(hdr_reject, 1'b0);
      check(last_wd, 8'h66);
      $display("test bad header done");
   endtask
   task automatic t_irq();
      // clock enable low freezes the pin
      ce = 1'b0;
      irq_req = 1'b1;
      repeat (10) @(negedge ref_clk);
      check(lnk.irq_pin, 1'b1);
      ce = 1'b1;
      repeat (10) @(negedge ref_clk);
      check(lnk.irq_pin, 1'b0);
      check(irq_pin_level, 1'b0);
      irq_active_high = 1'b1;
      repeat (10) @(negedge ref_clk);
      check(lnk.irq_pin, 1'b1);
      irq_req = 1'b0;
      repeat (10) @(negedge ref_clk);
      check(lnk.irq_pin, 1'b0);
      $display("test interrupt done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(mon_mode, 1'b0);
      check(lnk.irq_pin, 1'b1);
      t_alt();
      t_rw();
      t_const();
      t_reject();
      t_irq();
      close_out();
   end
endmodule
